// ===== inc/rbt_pkg.sv
// Constants, field layouts and carrier types of the registered bus transceiver.
package rbt_pkg;

    localparam int BUS_W      = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int CNT_W      = 3;

    // Register byte offsets on the AHB-Lite port.
    localparam logic [31:0] CTRL_OFS   = 32'h0000_0000;
    localparam logic [31:0] STORED_OFS = 32'h0000_0004;
    localparam logic [31:0] BUS_OFS    = 32'h0000_0008;
    localparam logic [31:0] LOG_OFS    = 32'h0000_000C;
    localparam logic [31:0] STATUS_OFS = 32'h0000_0010;
    localparam logic [31:0] ADDR_MASK  = 32'h0000_00FC;

    // Field positions.
    localparam int CTRL_W         = 5;
    localparam int STORED_B_LSB   = 8;
    localparam int LOG_VALID_BIT  = 31;
    localparam int STAT_EMPTY_BIT = 0;
    localparam int STAT_FULL_BIT  = 1;
    localparam int STAT_OVF_BIT   = 2;
    localparam int STAT_CNT_LSB   = 4;

    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
    localparam logic        HRESP_OKAY    = 1'h0;
    localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;
    localparam logic [7:0]  BYTE_ZERO     = 8'h00;

    typedef struct packed {
        logic invert;
        logic bToASourceSelect;
        logic aToBSourceSelect;
        logic bToAOutputEnable_b;
        logic aToBOutputEnable;
    } rbt_ctrl_t;

    // Both buses isolated, real-time selected, non-inverting.
    localparam rbt_ctrl_t CTRL_RESET = 5'h02;

    typedef struct packed {
        logic             capB;
        logic             capA;
        logic [BUS_W-1:0] dataB;
        logic [BUS_W-1:0] dataA;
    } rbt_log_t;

    localparam int LOG_W = $bits(rbt_log_t);

    typedef struct packed {
        logic [BUS_W-1:0] data;
        logic             oe_b;
    } rbt_drive_t;

    localparam rbt_drive_t DRIVE_RESET = 9'h001;

endpackage : rbt_pkg

// ===== rtl/rbt_sync.sv
// Two-stage synchroniser for pin inputs, frozen while the clock enable is low.
`timescale 1ns/1ps
module rbt_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic             clkEn,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= '0;
            dout   <= '0;
        end else if (clkEn) begin
            stage1 <= din;
            dout   <= stage1;
        end
    end

endmodule : rbt_sync

// ===== rtl/rbt_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module rbt_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic                     clock,
    input  wire logic                     rst_b,
    input  wire logic                     clkEn,
    input  wire logic                     inValid,
    output logic                          inReady,
    input  wire logic [WIDTH-1:0]         inData,
    output logic                          outValid,
    input  wire logic                     outReady,
    output logic      [WIDTH-1:0]         outData,
    output logic      [$clog2(DEPTH):0]   count
);

    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0] FULL_CNT = (PTR_W+1)'(DEPTH);
    localparam logic [PTR_W:0] ONE_CNT  = (PTR_W+1)'(1);
    localparam logic [PTR_W-1:0] LAST   = PTR_W'(DEPTH - 1);
    localparam logic [PTR_W-1:0] ONE    = PTR_W'(1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wrPtr;
    logic [PTR_W-1:0] rdPtr;
    wire              push = inValid && inReady;
    wire              pop  = outValid && outReady;

    assign inReady  = (count != FULL_CNT);
    assign outValid = (count != '0);
    assign outData  = mem[rdPtr];

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else if (clkEn) begin
            if (push) begin
                wrPtr <= (wrPtr == LAST) ? '0 : wrPtr + ONE;
            end
            if (pop) begin
                rdPtr <= (rdPtr == LAST) ? '0 : rdPtr + ONE;
            end
            if (push && !pop) begin
                count <= count + ONE_CNT;
            end else if (pop && !push) begin
                count <= count - ONE_CNT;
            end
        end
    end

    // Storage holds no control state, so it needs no reset.
    always_ff @(posedge clock) begin
        if (clkEn && push) begin
            mem[wrPtr] <= inData;
        end
    end

endmodule : rbt_fifo

// ===== rtl/rbt_top.sv
// Registered octal bus transceiver with AHB-Lite control and a capture log.
`timescale 1ns/1ps

// Functional notes
// - each register loads on its capture clock rising edge, regardless of controls.
// - A data, B data or both may be captured in the same cycle.
// - select low passes real-time bus data, select high passes stored data.
// - switching a select never glitches the driven bus.
// - the two enables decide whether A, B, both or neither bus is driven.
// - both enabled and real-time, each bus reinforces itself and holds.
// - A-side and B-side data have separate, independently clocked registers.
// - an inverting option complements passed data, real-time or stored.
// - A-to-B enable is active high, B-to-A enable is active low.
module rbt_top
    import rbt_pkg::*;
(
    input  wire logic                      clock,
    input  wire logic                      rst_b,
    input  wire logic                      clkEn,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic                           hreadyout,
    output logic      [31:0]               hrdata,
    output logic                           hresp,
    input  wire logic [rbt_pkg::BUS_W-1:0] aBusIn,
    input  wire logic [rbt_pkg::BUS_W-1:0] bBusIn,
    input  wire logic                      aSideCaptureClock,
    input  wire logic                      bSideCaptureClock,
    output rbt_pkg::rbt_drive_t            aDrive,
    output rbt_pkg::rbt_drive_t            bDrive,
    output logic                           logReady
);

    import rbt_pkg::*;

    // Pin synchronisation.
    logic [BUS_W-1:0] aSync;
    logic [BUS_W-1:0] bSync;
    logic [1:0]       capSync;
    logic [1:0]       capPrev;

    rbt_sync #(.WIDTH(BUS_W)) u_syncA (
        .clock (clock),
        .rst_b (rst_b),
        .clkEn (clkEn),
        .din   (aBusIn),
        .dout  (aSync)
    );

    rbt_sync #(.WIDTH(BUS_W)) u_syncB (
        .clock (clock),
        .rst_b (rst_b),
        .clkEn (clkEn),
        .din   (bBusIn),
        .dout  (bSync)
    );

    rbt_sync #(.WIDTH(2)) u_syncCap (
        .clock (clock),
        .rst_b (rst_b),
        .clkEn (clkEn),
        .din   ({bSideCaptureClock, aSideCaptureClock}),
        .dout  (capSync)
    );

    // Capture edges are taken from the second synchroniser stage only.
    wire captureA = capSync[0] && !capPrev[0];
    wire captureB = capSync[1] && !capPrev[1];

    // Storage registers, one per side.
    logic [BUS_W-1:0] storedA;
    logic [BUS_W-1:0] storedB;
    wire  [BUS_W-1:0] next_storedA = captureA ? aSync : storedA;
    wire  [BUS_W-1:0] next_storedB = captureB ? bSync : storedB;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            capPrev <= 2'h0;
            storedA <= BYTE_ZERO;
            storedB <= BYTE_ZERO;
        end else if (clkEn) begin
            capPrev <= capSync;
            storedA <= next_storedA;
            storedB <= next_storedB;
        end
    end

    // Control register.
    rbt_ctrl_t ctrl;
    rbt_ctrl_t next_ctrl;

    // Output path selection and optional complement.
    wire [BUS_W-1:0] aToBRaw =
        ctrl.aToBSourceSelect ? storedA : aSync;
    wire [BUS_W-1:0] bToARaw =
        ctrl.bToASourceSelect ? storedB : bSync;
    wire [BUS_W-1:0] aToBData =
        ctrl.invert ? ~aToBRaw : aToBRaw;
    wire [BUS_W-1:0] bToAData =
        ctrl.invert ? ~bToARaw : bToARaw;

    // With both sides enabled and real-time, each bus sees its own level
    // come back through the other side, so it holds once others float.
    rbt_drive_t next_bDrive;
    rbt_drive_t next_aDrive;
    assign next_bDrive.data = aToBData;
    assign next_bDrive.oe_b = !ctrl.aToBOutputEnable;
    assign next_aDrive.data = bToAData;
    assign next_aDrive.oe_b = ctrl.bToAOutputEnable_b;

    // The pins come straight from flip-flops: a select change shows as one
    // clean step with no mux decode hazard on the bus.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            aDrive <= DRIVE_RESET;
            bDrive <= DRIVE_RESET;
        end else if (clkEn) begin
            aDrive <= next_aDrive;
            bDrive <= next_bDrive;
        end
    end

    // Capture log: one entry per cycle holding any edge seen in it, so
    // simultaneous captures share one word and neither is lost.
    rbt_log_t logIn;
    rbt_log_t logOut;
    logic     logValid;
    logic     logPop;
    logic [CNT_W-1:0] logCount;
    wire      logPush = captureA || captureB;

    assign logIn.capA  = captureA;
    assign logIn.capB  = captureB;
    assign logIn.dataA = aSync;
    assign logIn.dataB = bSync;

    rbt_fifo #(.WIDTH(LOG_W), .DEPTH(FIFO_DEPTH)) u_log (
        .clock    (clock),
        .rst_b    (rst_b),
        .clkEn    (clkEn),
        .inValid  (logPush),
        .inReady  (logReady),
        .inData   (logIn),
        .outValid (logValid),
        .outReady (logPop),
        .outData  (logOut),
        .count    (logCount)
    );

    // A full log never blocks the storage registers; the lost entry is
    // flagged instead, since capture must not depend on software.
    logic overflow;
    wire  overflowSet = logPush && !logReady;

    // AHB-Lite slave: address phase is registered, writes land in the
    // data phase, read data is prepared at the address phase.
    logic        wrPending;
    logic [31:0] wrAddr;
    wire         addrPhase = hsel && hready && clkEn &&
                             ((htrans == HTRANS_NONSEQ) ||
                              (htrans == HTRANS_SEQ));
    wire  [31:0] addrWord  = haddr & ADDR_MASK;
    wire         rdAccess  = addrPhase && !hwrite;
    wire         wrCtrl    = wrPending && (wrAddr == CTRL_OFS);
    wire         wrStatus  = wrPending && (wrAddr == STATUS_OFS);
    wire         ovfClear  = wrStatus && hwdata[STAT_OVF_BIT];

    assign logPop    = rdAccess && (addrWord == LOG_OFS) && logValid;
    assign hreadyout = clkEn;
    assign hresp     = HRESP_OKAY;

    assign next_ctrl = wrCtrl ? rbt_ctrl_t'(hwdata[CTRL_W-1:0]) : ctrl;

    // Hardware set wins over a software clear in the same cycle.
    wire next_overflow = overflowSet || (overflow && !ovfClear);

    wire [31:0] ctrlWord   = {{(32-CTRL_W){1'b0}}, next_ctrl};
    wire [31:0] storedWord = {16'h0000, storedB, storedA};
    wire [31:0] busWord    = {16'h0000, bSync, aSync};
    wire [31:0] logWord    =
        {logValid, {(31-LOG_W){1'b0}}, logValid ? logOut : rbt_log_t'('0)};
    wire [31:0] statusWord =
        {{(28-CNT_W){1'b0}}, logCount, 1'b0, next_overflow,
         !logReady, !logValid};

    logic [31:0] next_rdata;
    always_comb begin
        unique case (addrWord)
            CTRL_OFS:   next_rdata = ctrlWord;
            STORED_OFS: next_rdata = storedWord;
            BUS_OFS:    next_rdata = busWord;
            LOG_OFS:    next_rdata = logWord;
            STATUS_OFS: next_rdata = statusWord;
            default:    next_rdata = WORD_ZERO;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wrPending <= 1'b0;
            wrAddr    <= WORD_ZERO;
            hrdata    <= WORD_ZERO;
            ctrl      <= CTRL_RESET;
            overflow  <= 1'b0;
        end else if (clkEn) begin
            wrPending <= addrPhase && hwrite;
            wrAddr    <= addrWord;
            if (rdAccess) begin
                hrdata <= next_rdata;
            end
            ctrl     <= next_ctrl;
            overflow <= next_overflow;
        end
    end

    // Transfer size is not checked: every access is treated as a word.
    wire unusedSize = ^hsize;

endmodule : rbt_top

// ===== tb/rbt_bus_model.sv
// Shared bus model: one outside driver plus the transceiver's own drive.
`timescale 1ns/1ps
module rbt_bus_model (
    input  wire logic                      clock,
    input  wire rbt_pkg::rbt_drive_t       devDrive,
    input  wire logic                      extEn,
    input  wire logic [rbt_pkg::BUS_W-1:0] extData,
    output logic      [rbt_pkg::BUS_W-1:0] level
);
    import rbt_pkg::*;
    logic [BUS_W-1:0] floatVal = BYTE_ZERO;
    // The lines have no keeper, so a released bus wanders every cycle.
    always_ff @(posedge clock) begin
        floatVal <= ~level;
    end
    assign level = extEn ? extData
                 : !devDrive.oe_b ? devDrive.data
                 : floatVal;
endmodule : rbt_bus_model

// ===== tb/rbt_top_asserts.sv
// Port-level checks of the registered bus transceiver.
`timescale 1ns/1ps
module rbt_top_asserts (
    input wire logic                 clock,
    input wire logic                 rst_b,
    input wire logic                 clkEn,
    input wire logic                 hsel,
    input wire logic [31:0]          haddr,
    input wire logic [1:0]           htrans,
    input wire logic                 hwrite,
    input wire logic [31:0]          hwdata,
    input wire logic                 hready,
    input wire logic                 hreadyout,
    input wire logic [31:0]          hrdata,
    input wire logic [7:0]           aBusIn,
    input wire logic [7:0]           bBusIn,
    input wire logic                 aSideCaptureClock,
    input wire rbt_pkg::rbt_drive_t  aDrive,
    input wire rbt_pkg::rbt_drive_t  bDrive
);
    import rbt_pkg::*;
    rbt_ctrl_t  sh;
    logic       wrPend;
    logic       capAq;
    logic [3:0] quiet;
    logic [3:0] ageA;
    wire        ctrlWr = wrPend && hreadyout;
    wire        taken  = hsel && hready && htrans[1] && clkEn;
    wire  [3:0] next_quiet = (!clkEn || ctrlWr) ? 4'h0
                           : quiet + {3'h0, ~&quiet};
    wire  [3:0] next_ageA  = (aSideCaptureClock && !capAq) ? 4'h0
                           : ageA + {3'h0, clkEn & ~&ageA};
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    // Control is mirrored from bus traffic, so no hierarchy is needed.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sh     <= CTRL_RESET;
            wrPend <= 1'b0;
            capAq  <= 1'b0;
            quiet  <= 4'h0;
            ageA   <= 4'h0;
        end else begin
            capAq <= aSideCaptureClock;
            quiet <= next_quiet;
            ageA  <= next_ageA;
            if (hreadyout) begin
                wrPend <= taken && hwrite && haddr[7:2] == 6'h00;
            end
            if (ctrlWr) begin
                sh <= rbt_ctrl_t'(hwdata[CTRL_W-1:0]);
            end
        end
    end
    chk_ab_enable: assert property (
        clkEn |=> bDrive.oe_b != $past(sh.aToBOutputEnable))
        else $error("A-to-B enable wrong");
    chk_ba_enable: assert property (
        clkEn |=> aDrive.oe_b == $past(sh.bToAOutputEnable_b))
        else $error("B-to-A enable wrong");
    chk_both_isolated: assert property (
        clkEn && !sh.aToBOutputEnable && sh.bToAOutputEnable_b
        |=> aDrive.oe_b && bDrive.oe_b) else $error("buses not isolated");
    chk_rt_to_b: assert property (
        quiet > 4'h3 && sh.aToBOutputEnable && !sh.aToBSourceSelect
        |-> bDrive.data == ($past(aBusIn, 3) ^ {BUS_W{sh.invert}}))
        else $error("real-time data on B wrong");
    chk_rt_to_a: assert property (
        quiet > 4'h3 && !sh.bToAOutputEnable_b && !sh.bToASourceSelect
        |-> aDrive.data == ($past(bBusIn, 3) ^ {BUS_W{sh.invert}}))
        else $error("real-time data on A wrong");
    chk_stored_steady: assert property (
        quiet > 4'h3 && ageA > 4'h7 && sh.aToBSourceSelect
        && sh.aToBOutputEnable |-> $stable(bDrive.data))
        else $error("stored data on B moved without a capture");
    chk_zero_wait: assert property (hreadyout == clkEn)
        else $error("ready does not follow clock enable");
    chk_rdata_hold: assert property (!(taken && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without a read");
    // A read in the cycle after a control write must already see the write.
    chk_ctrl_readback: assert property (
        taken && !hwrite && haddr[7:2] == 6'h00
        |=> hrdata[CTRL_W-1:0] == $past(ctrlWr
            ? rbt_ctrl_t'(hwdata[CTRL_W-1:0]) : sh))
        else $error("control read back wrong");
    cover property (ctrlWr);
    cover property (quiet > 4'h3 && !sh.aToBSourceSelect
                    && !sh.bToAOutputEnable_b);
    cover property (ageA == 4'h0 && sh.aToBSourceSelect);
endmodule : rbt_top_asserts

bind rbt_top rbt_top_asserts u_chk (
    .clock, .rst_b, .clkEn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
    .hready, .hreadyout, .hrdata, .aBusIn, .bBusIn, .aSideCaptureClock,
    .aDrive, .bDrive
);

// ===== tb/test_registered_bus_transceiver.sv
// Self-checking bench: registers, captures, drive paths and the capture log.
`timescale 1ns/1ps
module test_registered_bus_transceiver;
    import rbt_pkg::*;
    localparam logic [31:0] ALL  = 32'hFFFF_FFFF;
    localparam logic [31:0] LOGM = 32'h8003_00FF;
    logic             clock, rst_b, clkEn, hsel, hwrite, hreadyout, logReady;
    logic             capA, capB, extEnA, extEnB, hresp;
    logic [1:0]       htrans;
    logic [31:0]      haddr, hwdata, hrdata, rd;
    logic [BUS_W-1:0] extA, extB, aBus, bBus;
    rbt_drive_t       aDrive, bDrive;
    int               numErrors = 0;
    int               nTests = 0;
    rbt_top u_dut (
        .clock, .rst_b, .clkEn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata,
        .hresp, .aBusIn(aBus), .bBusIn(bBus), .aSideCaptureClock(capA),
        .bSideCaptureClock(capB), .aDrive, .bDrive, .logReady
    );
    rbt_bus_model u_busA (.clock, .devDrive(aDrive), .extEn(extEnA),
        .extData(extA), .level(aBus));
    rbt_bus_model u_busB (.clock, .devDrive(bDrive), .extEn(extEnB),
        .extData(extB), .level(bBus));
    task automatic finishTest();
        if (numErrors == 0 && nTests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finishTest
    task automatic chkEq(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
            numErrors++;
        end
    endtask : chkEq
    task automatic waitReady();
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (n >= 64) begin
            numErrors++;
            finishTest();
        end
    endtask : waitReady
    task automatic xfer(input logic [31:0] a, input logic w,
                        input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        waitReady();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitReady();
        rd = hrdata;
        chkEq({31'h0, hresp}, {31'h0, HRESP_OKAY});
    endtask : xfer
    task automatic chkRd(input logic [31:0] a, input logic [31:0] e,
                         input logic [31:0] m);
        xfer(a, 1'b0, WORD_ZERO);
        chkEq(rd & m, e);
    endtask : chkRd
    // Bus data is held well around the capture pulse, as the pins are synced.
    task automatic capture(input logic da, input logic db,
                           input logic [7:0] a, input logic [7:0] b);
        extA <= a;
        extB <= b;
        repeat (4) @(posedge clock);
        capA <= da;
        capB <= db;
        repeat (4) @(posedge clock);
        capA <= 1'b0;
        capB <= 1'b0;
        repeat (6) @(posedge clock);
    endtask : capture
    task automatic ctrlSee(input logic [31:0] c, input logic [15:0] e);
        xfer(CTRL_OFS, 1'b1, c);
        repeat (6) @(posedge clock);
        chkEq({16'h0, bBus, aBus}, {16'h0, e});
    endtask : ctrlSee
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        rst_b = 1'b0;
        clkEn = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        haddr = WORD_ZERO;
        hwdata = WORD_ZERO;
        {capA, capB, extEnA, extEnB} = 4'h3;
        extA = BYTE_ZERO;
        extB = BYTE_ZERO;
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        chkRd(CTRL_OFS, 32'(CTRL_RESET), ALL);
        chkEq({30'h0, aDrive.oe_b, bDrive.oe_b}, 32'h3);
        chkRd(32'h20, WORD_ZERO, ALL);
        // Selects are real-time here, so both clocks may rise together.
        capture(1'b1, 1'b1, 8'hA5, 8'h3C);
        chkRd(STORED_OFS, 32'h3CA5, ALL);
        capture(1'b1, 1'b0, 8'h5A, 8'hC3);
        chkRd(STORED_OFS, 32'h3C5A, ALL);
        capture(1'b0, 1'b1, 8'h5A, 8'hC3);
        xfer(STORED_OFS, 1'b1, ALL);
        chkRd(STORED_OFS, 32'hC35A, ALL);
        chkRd(LOG_OFS, 32'h8003_00A5, LOGM);
        chkRd(LOG_OFS, 32'h8001_005A, LOGM);
        chkRd(LOG_OFS, 32'h8002_005A, LOGM);
        chkRd(LOG_OFS, WORD_ZERO, ALL);
        for (int i = 0; i < 5; i++) begin
            capture(1'b1, 1'b0, 8'h10 + 8'(i), 8'hC3);
        end
        chkEq({31'h0, logReady}, WORD_ZERO);
        chkRd(STATUS_OFS, 32'h46, 32'h77);
        for (int i = 0; i < 4; i++) begin
            chkRd(LOG_OFS, 32'h8001_0010 + 32'(i), LOGM);
        end
        chkRd(STATUS_OFS, 32'h05, 32'h77);
        xfer(STATUS_OFS, 1'b1, 32'h04);
        chkRd(STATUS_OFS, 32'h01, 32'h77);
        extEnB <= 1'b0;
        extA <= 8'h96;
        ctrlSee(32'h03, 16'h9696);
        ctrlSee(32'h13, 16'h6996);
        ctrlSee(32'h17, 16'hEB96);
        extA <= 8'h14;
        ctrlSee(32'h07, 16'h1414);
        xfer(CTRL_OFS, 1'b1, 32'h03);
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            chkEq({24'h0, bBus}, 32'h14);
        end
        extEnA <= 1'b0;
        ctrlSee(32'h0D, 16'h14C3);
        extEnA <= 1'b1;
        extA <= 8'h66;
        ctrlSee(32'h03, 16'h6666);
        ctrlSee(32'h01, 16'h6666);
        extEnA <= 1'b0;
        repeat (10) @(posedge clock);
        chkEq({16'h0, bBus, aBus}, 32'h6666);
        xfer(CTRL_OFS, 1'b1, 32'h02);
        repeat (4) @(posedge clock);
        chkEq({30'h0, aDrive.oe_b, bDrive.oe_b}, 32'h3);
        clkEn <= 1'b0;
        repeat (2) @(posedge clock);
        chkEq({31'h0, hreadyout}, WORD_ZERO);
        clkEn <= 1'b1;
        repeat (2) @(posedge clock);
        finishTest();
    end
endmodule : test_registered_bus_transceiver
